// ### pkg/bps_cfg.svh
// register offsets, field positions, reset values and timing counts
`ifndef BPS_CFG_SVH
`define BPS_CFG_SVH
`define BPS_OFS_CTRL 12'h000
`define BPS_OFS_STAT 12'h004
`define BPS_OFS_IRQ_STAT 12'h008
`define BPS_OFS_IRQ_MASK 12'h00C
`define BPS_CTRL_LPS 0
`define BPS_CTRL_FSEL 7:4
`define BPS_CTRL_ALEN 8
`define BPS_CTRL_REPEAT 9
`define BPS_CTRL_OUT_BAT_OFF 10
`define BPS_CTRL_RESET 32'h0000_0000
`define BPS_EV_ALARM 0
`define BPS_EV_TO_BAT 1
`define BPS_EV_TO_MAIN 2
`define BPS_NEV 3
`define BPS_PULSE_MS 250
`define BPS_CLK_MHZ 100
`endif

// ### pkg/bps_pkg.sv
// types shared by the backup power switch block
package bps_pkg;
    typedef struct packed {
        logic below_bat;
        logic above_bat;
        logic below_trip;
        logic above_trip;
    } bps_cmp_t;
    typedef enum logic [2:0] {
        BPS_SEALED = 3'b001,
        BPS_MAIN = 3'b010,
        BPS_BATT = 3'b100
    } bps_state_t;
    typedef struct packed {
        logic o;
        logic oe;
    } bps_od_t;
endpackage

// ### hw/bps_top.sv
// backup power switch control with ahb-lite registers
`timescale 1ns/1ns
`include "bps_cfg.svh"
// ----------------------------------------------------------------
// How it works
// - normal: battery when below battery and trip
// - backup: return when above either level
// - backup mode silences serial clock and data
// - other outputs keep running in backup, except the shared pin when battery output off is set
// - readable total power loss flag
// - low power select ignores trip comparison
// - low power: switch when below battery
// - no battery use before first main power-up
// - select bits pick interrupt or clock out
// - interrupt mode pulls pin on alarm
// - repeating alarm gives periodic pulses
// - alarm status readable by polling, set only in interrupt mode
// - serial data only pulled low
// - low power select resets to zero
// ----------------------------------------------------------------
module bps_top #(
    parameter int PULSE_CYCLES = `BPS_PULSE_MS * 1000 * `BPS_CLK_MHZ
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [3:0] cmp_async,
    input wire logic power_lost_both,
    input wire logic alarm_match,
    input wire logic [14:0] freq_taps,
    input wire logic serial_clk_in,
    input wire logic serial_data_in,
    input wire logic serial_data_pull,
    output logic serial_clk_gated,
    output logic serial_data_gated,
    output logic serial_data_o,
    output logic serial_data_oe,
    output logic alarm_or_clock_out_pin_o,
    output logic alarm_or_clock_out_pin_oe,
    output logic on_battery,
    output logic irq
);
    initial begin
        if (PULSE_CYCLES < 1) begin
            $error("pulse length must be at least one cycle");
        end
        if (`BPS_NEV != 3) begin
            $error("event status layout holds three events");
        end
        if (`BPS_CLK_MHZ < 1) begin
            $error("clock rate must be at least one megahertz");
        end
    end

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = 8;
    logic [NSYNC-1:0] sync_in;
    logic [NSYNC-1:0] sync_s2;
    bps_pkg::bps_cmp_t cmp;
    logic lost_s;
    logic alarm_s;
    logic sclk_s;
    logic sdata_s;
    assign sync_in = {cmp_async, power_lost_both, alarm_match,
        serial_clk_in, serial_data_in};
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            // only the second flop is read outside this block
            logic s1;
            logic s2;
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                end else begin
                    s1 <= sync_in[gi];
                    s2 <= s1;
                end
            end
            assign sync_s2[gi] = s2;
        end
    endgenerate
    assign cmp = bps_pkg::bps_cmp_t'(sync_s2[7:4]);
    assign lost_s = sync_s2[3];
    assign alarm_s = sync_s2[2];
    assign sclk_s = sync_s2[1];
    assign sdata_s = sync_s2[0];

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [31:0] ctrl;
    logic [31:0] next_ctrl;
    logic [`BPS_NEV-1:0] ev_stat;
    logic [`BPS_NEV-1:0] next_ev_stat;
    logic [`BPS_NEV-1:0] ev_mask;
    logic [`BPS_NEV-1:0] next_ev_mask;
    logic loss_flag;
    logic next_loss_flag;
    logic [`BPS_NEV-1:0] ev;
    logic dp_write;
    logic next_dp_write;
    logic [11:0] dp_addr;
    logic [11:0] next_dp_addr;
    logic [31:0] next_hrdata;
    logic lps;
    logic out_off;
    assign lps = ctrl[`BPS_CTRL_LPS];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ------------------------------------------------------------
    // read words
    // ------------------------------------------------------------
    logic [31:0] stat_word;
    logic [31:0] ev_word;
    logic [31:0] mask_word;
    // loss flag and event word read their next value so a same-cycle event is not lost
    assign stat_word = {28'h0000000, ev_stat[`BPS_EV_ALARM], on_battery,
        1'b0, next_loss_flag};
    assign ev_word = {{(32-`BPS_NEV){1'b0}}, next_ev_stat};
    assign mask_word = {{(32-`BPS_NEV){1'b0}}, ev_mask};

    always_comb begin
        next_dp_write = 1'b0;
        next_dp_addr = dp_addr;
        if (hsel && hready && htrans[1]) begin
            next_dp_write = hwrite;
            next_dp_addr = haddr[11:0];
        end
        next_ctrl = ctrl;
        next_ev_mask = ev_mask;
        next_ev_stat = ev_stat;
        next_loss_flag = loss_flag | lost_s;
        if (dp_write) begin
            unique case (dp_addr)
                `BPS_OFS_CTRL: next_ctrl = hwdata;
                `BPS_OFS_STAT: next_loss_flag = lost_s;
                `BPS_OFS_IRQ_STAT: next_ev_stat = ev_stat & ~hwdata[`BPS_NEV-1:0];
                `BPS_OFS_IRQ_MASK: next_ev_mask = hwdata[`BPS_NEV-1:0];
                default: ;
            endcase
        end
        next_ev_stat = next_ev_stat | ev; // set wins
        next_hrdata = 32'h0000_0000;
        if (hsel && hready && htrans[1] && !hwrite) begin
            unique case (haddr[11:0])
                `BPS_OFS_CTRL: next_hrdata = ctrl;
                `BPS_OFS_STAT: next_hrdata = stat_word;
                `BPS_OFS_IRQ_STAT: next_hrdata = ev_word;
                `BPS_OFS_IRQ_MASK: next_hrdata = mask_word;
                default: next_hrdata = 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= `BPS_CTRL_RESET;
            ev_stat <= 3'h0;
            ev_mask <= 3'h0;
            loss_flag <= 1'b0;
            dp_write <= 1'b0;
            dp_addr <= 12'h000;
            hrdata <= 32'h0000_0000;
        end else begin
            ctrl <= next_ctrl;
            ev_stat <= next_ev_stat;
            ev_mask <= next_ev_mask;
            loss_flag <= next_loss_flag;
            dp_write <= next_dp_write;
            dp_addr <= next_dp_addr;
            hrdata <= next_hrdata;
        end
    end
    assign irq = |(ev_stat & ev_mask);

    // ------------------------------------------------------------
    // supply selection
    // ------------------------------------------------------------
    bps_pkg::bps_state_t state;
    bps_pkg::bps_state_t next_state;
    logic go_bat;
    logic go_main;
    always_comb begin
        // low power select drops the trip term
        go_bat = cmp.below_bat && (lps || cmp.below_trip);
        go_main = cmp.above_bat || (!lps && cmp.above_trip);
        next_state = state;
        unique case (state)
            bps_pkg::BPS_SEALED: if (go_main) begin
                next_state = bps_pkg::BPS_MAIN;
            end
            bps_pkg::BPS_MAIN: if (go_bat) begin
                next_state = bps_pkg::BPS_BATT;
            end
            bps_pkg::BPS_BATT: if (go_main) begin
                next_state = bps_pkg::BPS_MAIN;
            end
            default: next_state = bps_pkg::BPS_SEALED;
        endcase
    end
    // sealed start: no battery draw before the first main power-up
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= bps_pkg::BPS_SEALED;
        end else begin
            state <= next_state;
        end
    end
    assign on_battery = (state == bps_pkg::BPS_BATT);
    assign ev[`BPS_EV_TO_BAT] = go_bat && state == bps_pkg::BPS_MAIN;
    assign ev[`BPS_EV_TO_MAIN] = go_main && state == bps_pkg::BPS_BATT;

    // ------------------------------------------------------------
    // serial gating
    // ------------------------------------------------------------
    assign serial_clk_gated = sclk_s && !on_battery;
    assign serial_data_gated = sdata_s && !on_battery;
    assign serial_data_o = 1'b0;
    assign serial_data_oe = serial_data_pull && !on_battery;

    // ------------------------------------------------------------
    // alarm and shared output pin
    // ------------------------------------------------------------
    logic alarm_d;
    logic alarm_rise;
    logic [31:0] pulse_cnt;
    logic [31:0] next_pulse_cnt;
    logic pin_low;
    logic next_pin_low;
    logic [3:0] fsel;
    logic int_mode;
    logic repeat_mode;
    logic tap_level;
    assign fsel = ctrl[`BPS_CTRL_FSEL];
    assign int_mode = (fsel == 4'h0);
    assign repeat_mode = ctrl[`BPS_CTRL_REPEAT];
    // code n drives tap n-1; code 0 frees the pin for alarms
    assign tap_level = int_mode ? 1'b1 : freq_taps[fsel - 4'h1];
    assign out_off = ctrl[`BPS_CTRL_OUT_BAT_OFF] && on_battery;
    assign alarm_rise = alarm_s && !alarm_d && ctrl[`BPS_CTRL_ALEN]
        && int_mode;
    assign ev[`BPS_EV_ALARM] = alarm_rise;
    always_comb begin
        next_pulse_cnt = pulse_cnt;
        next_pin_low = 1'b0;
        if (alarm_rise && repeat_mode) begin
            next_pulse_cnt = 32'(PULSE_CYCLES);
        end else if (pulse_cnt != 32'h0) begin
            next_pulse_cnt = pulse_cnt - 32'h1;
        end
        if (int_mode) begin
            // single mode holds low until status cleared
            next_pin_low = repeat_mode ? (next_pulse_cnt != 32'h0)
                : next_ev_stat[`BPS_EV_ALARM];
        end else begin
            next_pin_low = !tap_level;
        end
        if (out_off) begin
            next_pin_low = 1'b0;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alarm_d <= 1'b0;
            pulse_cnt <= 32'h0;
            pin_low <= 1'b0;
        end else begin
            alarm_d <= alarm_s;
            pulse_cnt <= next_pulse_cnt;
            pin_low <= next_pin_low;
        end
    end
    assign alarm_or_clock_out_pin_o = 1'b0;
    assign alarm_or_clock_out_pin_oe = pin_low;
endmodule

// ### dv/bps_supply_model.sv
// comparator model of the main supply against battery and trip level
`timescale 1ns/1ns
module bps_supply_model #(
    parameter int TRIP_MV = 2200
) (
    input wire logic [15:0] vdd_mv,
    input wire logic [15:0] vbat_mv,
    output logic [3:0] cmp_async
);
    // order: below_bat, above_bat, below_trip, above_trip
    assign cmp_async[3] = vdd_mv + 16'h0032 < vbat_mv;
    assign cmp_async[2] = vdd_mv > vbat_mv + 16'h0032;
    assign cmp_async[1] = vdd_mv < TRIP_MV[15:0];
    assign cmp_async[0] = vdd_mv > TRIP_MV[15:0] + 16'h001E;
endmodule

// ### dv/bps_props.sv
// port assertions for the backup power switch block
`timescale 1ns/1ns
module bps_props (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [3:0] cmp_async,
    input wire logic serial_data_pull,
    input wire logic serial_clk_gated,
    input wire logic serial_data_gated,
    input wire logic serial_data_o,
    input wire logic serial_data_oe,
    input wire logic alarm_or_clock_out_pin_o,
    input wire logic on_battery
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sda_gate_a: assert property (
        serial_data_oe == (serial_data_pull && !on_battery))
        else $error("data driver wrong for mode");
    sda_low_a: assert property (!serial_data_o)
        else $error("data line driven high");
    data_gate_a: assert property (on_battery |-> !serial_data_gated)
        else $error("data input live in backup");
    clk_gate_a: assert property (
        on_battery ##1 on_battery |-> !serial_clk_gated)
        else $error("serial clock live in backup");
    to_batt_a: assert property (
        $rose(on_battery) |-> $past(cmp_async[3], 3))
        else $error("backup entered without low supply");
    to_main_a: assert property (
        $fell(on_battery) |-> $past(cmp_async[2] || cmp_async[0], 3))
        else $error("backup left without supply return");
    hold_main_a: assert property (
        (!on_battery && !cmp_async[3]) [*3] |=> !on_battery)
        else $error("backup entered while supply above battery");
    hold_batt_a: assert property (
        (on_battery && !cmp_async[2] && !cmp_async[0]) [*3] |=> on_battery)
        else $error("backup left inside hysteresis");
    pin_od_a: assert property (!alarm_or_clock_out_pin_o)
        else $error("shared pin driven high");
endmodule
bind bps_top bps_props bps_props_inst (.hclk, .hresetn, .cmp_async,
    .serial_data_pull, .serial_clk_gated, .serial_data_gated,
    .serial_data_o, .serial_data_oe, .alarm_or_clock_out_pin_o, .on_battery);

// ### dv/test_backup_power_switch_control.sv
// self-checking bench for the backup power switch block
`timescale 1ns/1ns
module test_backup_power_switch_control;
    logic hclk = 1'h0;
    logic hresetn = 1'h0;
    logic hsel = 1'h0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = '0;
    logic hwrite = 1'h0;
    logic [31:0] hwdata = '0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, serial_clk_gated, serial_data_gated;
    logic serial_data_o, serial_data_oe, on_battery, irq, pin_o, pin_oe;
    logic rd = 1'h0;
    logic power_lost_both = 1'h0;
    logic alarm_match = 1'h0;
    logic serial_data_pull = 1'h0;
    logic [15:0] vdd = '0;
    logic [14:0] taps = '0;
    logic [15:0] vbat = 16'h0BB8;
    logic [3:0] cmp;
    int n_fail = 0;
    int cmp_count = 0;
    logic [31:0] exp_q[$];
    always #5 hclk = ~hclk;
    bps_supply_model bps_supply_model_inst (.vdd_mv(vdd), .vbat_mv(vbat),
        .cmp_async(cmp));
    bps_top #(.PULSE_CYCLES(20)) bps_top_inst (.hclk, .hresetn, .hsel,
        .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
        .hrdata, .hreadyout, .hresp, .cmp_async(cmp), .power_lost_both,
        .alarm_match, .freq_taps(taps), .serial_clk_in(1'h0),
        .serial_data_in(1'h1), .serial_data_pull, .serial_clk_gated,
        .serial_data_gated, .serial_data_o, .serial_data_oe,
        .alarm_or_clock_out_pin_o(pin_o), .alarm_or_clock_out_pin_oe(pin_oe),
        .on_battery, .irq);
    task automatic chk(logic [32:0] got, logic [32:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    always @(posedge hclk) begin
        if (rd) begin
            chk({hrdata, hresp}, {exp_q.pop_front(), 1'h0});
        end
    end
    task automatic bus(logic w, logic [31:0] a, logic [31:0] d);
        hsel <= 1'h1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        rd <= !w;
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        rd <= 1'h0;
    endtask
    task automatic rdx(logic [31:0] a, logic [31:0] e);
        exp_q.push_back(e);
        bus(1'h0, a, '0);
    endtask
    task automatic sup(logic [15:0] v, logic e);
        vdd <= v;
        repeat (5) @(posedge hclk);
        chk(on_battery, e);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #200000;
        n_fail++;
        close_out();
    end
    initial begin
        void'($urandom(32'hCC1937EC));
        repeat (12) @(posedge hclk);
        hresetn <= 1'h1;
        serial_data_pull <= 1'h1;
        rdx(32'h0, 32'h0);
        sup(16'h01F4, 1'h0);
        $display("test sealed done");
        sup(16'h0CE4, 1'h0);
        chk({serial_data_oe, serial_data_gated}, 2'h3);
        sup(16'h09C4, 1'h0);
        sup(16'h03E8 + 16'($urandom_range(900)), 1'h1);
        chk({serial_data_oe, serial_data_gated}, 2'h0);
        sup(16'h08A7, 1'h1);
        sup(16'h08C0, 1'h0);
        $display("test normal switching done");
        bus(1'h1, 32'h0, 32'h1);
        rdx(32'h0, 32'h1);
        sup(16'h0B54, 1'h1);
        rdx(32'h4, 32'h4);
        sup(16'h0C1C, 1'h0);
        $display("test low power switching done");
        power_lost_both <= 1'h1;
        repeat (4) @(posedge hclk);
        power_lost_both <= 1'h0;
        rdx(32'h4, 32'h1);
        bus(1'h1, 32'h4, 32'h0);
        rdx(32'h4, 32'h0);
        rdx(32'h10, 32'h0);
        $display("test status done");
        bus(1'h1, 32'h0, 32'h100);
        alarm_match <= 1'h1;
        repeat (4) @(posedge hclk);
        alarm_match <= 1'h0;
        rdx(32'h8, 32'h7);
        chk({irq, pin_oe}, 2'h1);
        rdx(32'h4, 32'h8);
        bus(1'h1, 32'hC, 32'h1);
        @(posedge hclk);
        chk(irq, 1'h1);
        bus(1'h1, 32'h8, 32'h7);
        @(posedge hclk);
        chk(irq, 1'h0);
        rdx(32'h8, 32'h0);
        $display("test alarm done");
        bus(1'h1, 32'h0, 32'h10);
        taps <= 15'h0001;
        repeat (2) @(posedge hclk);
        chk(pin_oe, 1'h0);
        taps <= 15'h0000;
        repeat (2) @(posedge hclk);
        chk(pin_oe, 1'h1);
        $display("test clock out done");
        bus(1'h1, 32'h0, 32'h300);
        alarm_match <= 1'h1;
        repeat (4) @(posedge hclk);
        chk(pin_oe, 1'h1);
        alarm_match <= 1'h0;
        repeat (20) @(posedge hclk);
        chk(pin_oe, 1'h0);
        rdx(32'h8, 32'h1);
        $display("test repeat alarm done");
        bus(1'h1, 32'h0, 32'h500);
        repeat (2) @(posedge hclk);
        chk(pin_oe, 1'h1);
        sup(16'h05DC, 1'h1);
        chk(pin_oe, 1'h0);
        sup(16'h0CE4, 1'h0);
        chk(pin_oe, 1'h1);
        $display("test battery output off done");
        hresetn <= 1'h0;
        repeat (2) @(posedge hclk);
        chk({on_battery, irq, pin_oe}, 3'h0);
        hresetn <= 1'h1;
        rdx(32'h0, 32'h0);
        sup(16'h0CE4, 1'h0);
        $display("test mid reset done");
        close_out();
    end
endmodule
